/* bsp_pkg.sv */
// constants for the transfer statistics and power-management status block
// assumes an apb slave at 32 bits and one clock, clk_sys
// How it works
// - low byte of statistics register reports dwords moved by bus-master transfers
// - dword count sums transfers since last read, saturating at 255, cleared by that read
// - upper sixteen bits sum clocks from read request to completion, read-cleared
// - wake event sets wake flag bit 15 regardless of wake signal enable
// - writing one to wake flag clears it and drops the wake request; zero ignored
// - data scale field bits 14 and 13 always read zero
// - status register holds a four-bit data select field
package bsp_pkg;
  localparam logic [11:0] bsp_stat_off = 12'h000;
  localparam logic [11:0] bsp_pmcs_off = 12'h004;
  localparam logic [11:0] bsp_isr_off = 12'h008;
  localparam logic [11:0] bsp_imr_off = 12'h00c;
  localparam int bsp_dw_lsb = 0;
  localparam int bsp_dw_w = 8;
  localparam int bsp_clk_lsb = 16;
  localparam int bsp_clk_w = 16;
  localparam int bsp_wake_bit = 15;
  localparam int bsp_dscale_lsb = 13;
  localparam int bsp_dsel_lsb = 9;
  localparam logic [7:0] bsp_dw_rst = 8'h00;
  localparam logic [15:0] bsp_clk_rst = 16'h0000;
  localparam logic [1:0] bsp_dscale_val = 2'h0;
  localparam logic [3:0] bsp_dsel_val = 4'h0;
  localparam logic [1:0] bsp_irq_rst = 2'h0;
  localparam int bsp_irq_wake = 0;
  localparam int bsp_irq_sat = 1;
  typedef enum logic [0:0] {bsp_lat_idle = 1'b0, bsp_lat_busy = 1'b1} bsp_lat_type;
endpackage

/* bsp_sat_acc.sv */
// saturating accumulator, cleared by a read strobe
// assumes add and clear come from the same clock domain
module bsp_sat_acc #(
  parameter int width = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic [width-1:0] add,
  output logic [width-1:0] value,
  output logic saturated
);
  logic [width-1:0] acc_reg;
  logic [width:0] sum;
  logic [width-1:0] acc_next;
  // saturate instead of wrap so software never sees a small wrong total
  assign sum = {1'b0, acc_reg} + {1'b0, add};
  // a read restarts the total, so no overflow is reported in that cycle
  assign saturated = sum[width] & ~clear;
  // a read clears, but this cycle's amount starts the new total
  assign acc_next = clear ? add : (sum[width] ? {width{1'b1}} : sum[width-1:0]);
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) acc_reg <= '0;
    else acc_reg <= acc_next;
  end
  assign value = acc_reg;
endmodule // bsp_sat_acc

/* bsp_stat_pm.sv */
// statistics counters and power-management status register behind apb
// assumes the bus-master engine pulses dword strobes and read request/done
//
// Our own choices: the APB slave port and the address map.
module bsp_stat_pm (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] dword_moved,
  input wire logic read_req,
  input wire logic read_done,
  input wire logic wake_event,
  input wire logic wake_signal_enable,
  output logic wake_request_n,
  output logic irq
);
  import bsp_pkg::*;
  ////////////////////////////////////////////////////////////////
  logic acc_phase, wr_acc, rd_setup;
  logic hit_stat, hit_pmcs, hit_isr, hit_imr, hit_any;
  // address compare shared by every register decode
  function automatic logic bsp_hit(input logic [11:0] addr, input logic [11:0] off);
    return addr == off;
  endfunction
  assign acc_phase = psel & penable;
  assign wr_acc = acc_phase & pwrite;
  // read side effects fire at the setup edge that captures prdata, so no event slips in between
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit_stat = bsp_hit(paddr, bsp_stat_off);
  assign hit_pmcs = bsp_hit(paddr, bsp_pmcs_off);
  assign hit_isr = bsp_hit(paddr, bsp_isr_off);
  assign hit_imr = bsp_hit(paddr, bsp_imr_off);
  assign hit_any = hit_stat | hit_pmcs | hit_isr | hit_imr;
  // zero wait states
  assign pready = 1'b1;
  assign pslverr = acc_phase & ~hit_any;
  ////////////////////////////////////////////////////////////////
  logic stat_clear;
  logic [7:0] dw_add, dw_value;
  logic [15:0] clk_add, clk_value;
  logic dw_sat, clk_sat;
  bsp_lat_type lat_reg, lat_next;
  assign stat_clear = rd_setup & hit_stat;
  assign dw_add = {4'h0, dword_moved};
  always_comb begin
    lat_next = lat_reg;
    case (lat_reg)
      bsp_lat_idle: if (read_req & ~read_done) lat_next = bsp_lat_busy;
      bsp_lat_busy: if (read_done) lat_next = bsp_lat_idle;
      default: lat_next = bsp_lat_idle;
    endcase
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) lat_reg <= bsp_lat_idle;
    else lat_reg <= lat_next;
  end
  // the request cycle counts as one clock, the completion cycle does not
  assign clk_add = {15'h0000, read_req | ((lat_reg == bsp_lat_busy) & ~read_done)};
  bsp_sat_acc #(.width(bsp_dw_w)) u_dw (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clear(stat_clear),
    .add(dw_add),
    .value(dw_value),
    .saturated(dw_sat)
  );
  bsp_sat_acc #(.width(bsp_clk_w)) u_clk (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clear(stat_clear),
    .add(clk_add),
    .value(clk_value),
    .saturated(clk_sat)
  );
  ////////////////////////////////////////////////////////////////
  logic wake_reg, wake_next, wake_clr;
  assign wake_clr = wr_acc & hit_pmcs & pwdata[bsp_wake_bit];
  // set regardless of enable; set beats clear
  assign wake_next = wake_event | (wake_reg & ~wake_clr);
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) wake_reg <= 1'b0;
    else wake_reg <= wake_next;
  end
  // wake request follows flag when enabled
  assign wake_request_n = ~(wake_reg & wake_signal_enable);
  ////////////////////////////////////////////////////////////////
  logic [1:0] isr_reg, isr_next, imr_reg, imr_next, irq_ev;
  logic isr_rd;
  assign irq_ev[bsp_irq_wake] = wake_event;
  assign irq_ev[bsp_irq_sat] = dw_sat | clk_sat;
  assign isr_rd = rd_setup & hit_isr;
  assign isr_next = irq_ev | (isr_rd ? 2'h0 : isr_reg);
  assign imr_next = (wr_acc & hit_imr) ? pwdata[1:0] : imr_reg;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      isr_reg <= bsp_irq_rst;
      imr_reg <= bsp_irq_rst;
    end else begin
      isr_reg <= isr_next;
      imr_reg <= imr_next;
    end
  end
  assign irq = |(isr_reg & imr_reg);
  ////////////////////////////////////////////////////////////////
  logic [31:0] stat_word, pmcs_word, rd_mux, prdata_reg;
  assign stat_word = {clk_value, 8'h00, dw_value};
  // scale and select read zero, writes ignored
  assign pmcs_word = {16'h0000, wake_reg, bsp_dscale_val, bsp_dsel_val, 9'h000};
  assign rd_mux = hit_stat ? stat_word :
                  hit_pmcs ? pmcs_word :
                  hit_isr ? {30'h0, isr_reg} :
                  hit_imr ? {30'h0, imr_reg} : 32'h0;
  // data registered in setup so it stands through the access phase
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) prdata_reg <= 32'h0;
    else if (psel & ~penable) prdata_reg <= rd_mux;
  end
  assign prdata = prdata_reg;
  ////////////////////////////////////////////////////////////////
  // read clears the dword count
  a_stat_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    stat_clear ##1 1'b1 |-> dw_value == $past(dw_add)) else $error("dword count not cleared by read");
  a_dw_grow: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!stat_clear && !dw_sat) |=> dw_value == $past(dw_value) + $past(dw_add)) else $error("dword sum wrong");
  a_clk_grow: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (lat_reg == bsp_lat_busy && !read_done && !stat_clear && !clk_sat) |=> clk_value == $past(clk_value) + 16'h0001)
    else $error("latency clock not counted");
  sequence s_wake_set;
    wake_event;
  endsequence
  a_wake_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_wake_set |=> wake_reg) else $error("wake flag not set");
  // write one clears when no event
  a_wake_clr: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wake_clr && !wake_event) |=> !wake_reg ##0 wake_request_n) else $error("wake flag not cleared");
  a_wake_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wake_reg && !wake_clr) |=> wake_reg) else $error("wake flag lost");
  a_scale_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (psel && !penable && hit_pmcs) |=> prdata[14:13] == 2'h0) else $error("scale field not zero");
  a_sel_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (psel && !penable && hit_pmcs) |=> prdata[31:16] == 16'h0 && prdata[12:0] == 13'h0)
    else $error("select or reserved not zero");
  // interrupt follows unmasked status
  a_irq_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wake_event && imr_reg[bsp_irq_wake] && !(wr_acc && hit_imr)) |=> irq) else $error("irq missing");
  ////////////////////////////////////////////////////////////////
  sequence s_rd_setup;
    psel && !penable && !pwrite;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_pmcs_rd;
    psel && !penable && !pwrite && hit_pmcs;
  endsequence
  sequence s_wake_wr1;
    wr_acc && hit_pmcs && pwdata[bsp_wake_bit] && !wake_event;
  endsequence
  property p_stat_dw;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rd_setup ##0 hit_stat |=> prdata[bsp_dw_lsb +: bsp_dw_w] == $past(dw_value);
  endproperty
  a_stat_dw: assert property (p_stat_dw) else $error("dword field wrong on read");
  property p_stat_clk;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rd_setup ##0 hit_stat |=> prdata[bsp_clk_lsb +: bsp_clk_w] == $past(clk_value);
  endproperty
  a_stat_clk: assert property (p_stat_clk) else $error("latency field wrong on read");
  property p_stat_resv;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rd_setup ##0 hit_stat |=> prdata[15:8] == 8'h00;
  endproperty
  a_stat_resv: assert property (p_stat_resv) else $error("statistics reserved bits not zero");
  property p_dw_clear;
    @(posedge clk_sys) disable iff (sys_rst)
    (stat_clear && dword_moved == 4'h0) |=> dw_value == bsp_dw_rst;
  endproperty
  a_dw_clear: assert property (p_dw_clear) else $error("dword count survived read");
  property p_clk_clear;
    @(posedge clk_sys) disable iff (sys_rst)
    (stat_clear && clk_add == 16'h0000) |=> clk_value == bsp_clk_rst;
  endproperty
  a_clk_clear: assert property (p_clk_clear) else $error("latency count survived read");
  property p_dw_sat;
    @(posedge clk_sys) disable iff (sys_rst)
    (dw_sat && !stat_clear) |=> dw_value == 8'hff;
  endproperty
  a_dw_sat: assert property (p_dw_sat) else $error("dword count wrapped");
  property p_clk_idle;
    @(posedge clk_sys) disable iff (sys_rst)
    (lat_reg == bsp_lat_idle && !read_req && !stat_clear) |=> clk_value == $past(clk_value);
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("latency counted while idle");
  property p_clk_done;
    @(posedge clk_sys) disable iff (sys_rst)
    (lat_reg == bsp_lat_busy && read_done && !read_req && !stat_clear) |=> clk_value == $past(clk_value);
  endproperty
  a_clk_done: assert property (p_clk_done) else $error("completion clock counted");
  property p_lat_start;
    @(posedge clk_sys) disable iff (sys_rst)
    (lat_reg == bsp_lat_idle && read_req && !read_done) |=> lat_reg == bsp_lat_busy;
  endproperty
  a_lat_start: assert property (p_lat_start) else $error("latency tracker not started");
  property p_lat_end;
    @(posedge clk_sys) disable iff (sys_rst)
    (lat_reg == bsp_lat_busy && read_done) |=> lat_reg == bsp_lat_idle;
  endproperty
  a_lat_end: assert property (p_lat_end) else $error("latency tracker not stopped");
  property p_req_first;
    @(posedge clk_sys) disable iff (sys_rst)
    (lat_reg == bsp_lat_idle && read_req && !stat_clear && !clk_sat) |=> clk_value == $past(clk_value) + 16'h0001;
  endproperty
  a_req_first: assert property (p_req_first) else $error("request clock not counted");
  property p_wake_quiet;
    @(posedge clk_sys) disable iff (sys_rst)
    (!wake_reg && !wake_event) |=> !wake_reg;
  endproperty
  a_wake_quiet: assert property (p_wake_quiet) else $error("wake flag set without event");
  property p_wake_any_en;
    @(posedge clk_sys) disable iff (sys_rst)
    (wake_event && !wake_signal_enable) |=> wake_reg;
  endproperty
  a_wake_any_en: assert property (p_wake_any_en) else $error("wake flag needs enable");
  property p_req_on;
    @(posedge clk_sys) disable iff (sys_rst)
    (wake_reg && wake_signal_enable) |-> !wake_request_n;
  endproperty
  a_req_on: assert property (p_req_on) else $error("wake request missing");
  property p_wr1_read;
    @(posedge clk_sys) disable iff (sys_rst)
    s_wake_wr1 ##1 !wake_event ##1 (s_pmcs_rd ##0 !wake_event) |=> !prdata[bsp_wake_bit];
  endproperty
  a_wr1_read: assert property (p_wr1_read) else $error("cleared wake flag read back set");
  // wake status latched
  property p_isr_wake;
    @(posedge clk_sys) disable iff (sys_rst)
    wake_event |=> isr_reg[bsp_irq_wake];
  endproperty
  a_isr_wake: assert property (p_isr_wake) else $error("wake status not latched");
  // status read clears
  property p_isr_clear;
    @(posedge clk_sys) disable iff (sys_rst)
    (isr_rd && irq_ev == 2'h0) |=> isr_reg == bsp_irq_rst;
  endproperty
  a_isr_clear: assert property (p_isr_clear) else $error("status not cleared by read");
  // status sticky otherwise
  property p_isr_keep;
    @(posedge clk_sys) disable iff (sys_rst)
    !isr_rd |=> (isr_reg & $past(isr_reg)) == $past(isr_reg);
  endproperty
  a_isr_keep: assert property (p_isr_keep) else $error("status bit lost");
  // saturation status latched
  property p_isr_sat;
    @(posedge clk_sys) disable iff (sys_rst)
    (dw_sat || clk_sat) |=> isr_reg[bsp_irq_sat];
  endproperty
  a_isr_sat: assert property (p_isr_sat) else $error("saturation not latched");
  // mask write lands
  property p_imr_write;
    @(posedge clk_sys) disable iff (sys_rst)
    (wr_acc && hit_imr) |=> imr_reg == $past(pwdata[1:0]);
  endproperty
  a_imr_write: assert property (p_imr_write) else $error("mask write lost");
  // unmapped read zero
  property p_err_read;
    @(posedge clk_sys) disable iff (sys_rst)
    s_rd_setup ##0 !hit_any |=> prdata == 32'h0;
  endproperty
  a_err_read: assert property (p_err_read) else $error("unmapped read not zero");
  // read data stands
  property p_data_stand;
    @(posedge clk_sys) disable iff (sys_rst)
    !(psel && !penable) |=> $stable(prdata);
  endproperty
  a_data_stand: assert property (p_data_stand) else $error("read data moved outside setup");
  property p_sel_value;
    @(posedge clk_sys) disable iff (sys_rst)
    s_pmcs_rd |=> prdata[bsp_dsel_lsb +: 4] == bsp_dsel_val;
  endproperty
  a_sel_value: assert property (p_sel_value) else $error("data select not zero");
  property p_scale_value;
    @(posedge clk_sys) disable iff (sys_rst)
    s_pmcs_rd |=> prdata[bsp_dscale_lsb +: 2] == bsp_dscale_val;
  endproperty
  a_scale_value: assert property (p_scale_value) else $error("data scale not zero");
  property p_wake_read;
    @(posedge clk_sys) disable iff (sys_rst)
    s_pmcs_rd |=> prdata[bsp_wake_bit] == $past(wake_reg);
  endproperty
  a_wake_read: assert property (p_wake_read) else $error("wake flag misread");
endmodule // bsp_stat_pm

/* bsp_engine_model.sv */
// bus-master engine and wake detector model on the far side of bsp_stat_pm
// assumes one caller at a time, all changes right after a rising edge
module bsp_engine_model (
  input wire logic clk_sys,
  output logic [3:0] dword_moved,
  output logic read_req,
  output logic read_done,
  output logic wake_event
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    dword_moved = 4'h0;
    read_req = 1'b0;
    read_done = 1'b0;
    wake_event = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // random dword counts, one per cycle; sum goes back to the caller
  task automatic burst(input int n, output int sum);
    logic [3:0] v;
    sum = 0;
    repeat (n) begin
      @(posedge clk_sys);
      v = 4'($urandom);
      dword_moved <= v;
      sum += v;
    end
    @(posedge clk_sys);
    dword_moved <= 4'h0;
  endtask
  // request, then completion lat cycles later
  task automatic fetch(input int lat);
    @(posedge clk_sys);
    read_req <= 1'b1;
    @(posedge clk_sys);
    read_req <= 1'b0;
    repeat (lat - 1) @(posedge clk_sys);
    read_done <= 1'b1;
    @(posedge clk_sys);
    read_done <= 1'b0;
  endtask
  task automatic wake();
    @(posedge clk_sys);
    wake_event <= 1'b1;
    @(posedge clk_sys);
    wake_event <= 1'b0;
  endtask
endmodule // bsp_engine_model

/* bus_statistics_and_pm_status_tb.sv */
// self-checking bench for bsp_stat_pm over apb
// assumes zero-wait apb answers; read results checked from a queue
module bus_statistics_and_pm_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bsp_pkg::*;
  logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, wake_signal_enable = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic pready, pslverr, read_req, read_done, wake_event, wake_request_n, irq;
  logic [3:0] dword_moved;
  logic [32:0] rq[$];
  int errors = 0, checks_done = 0, s;
  always #4 clk_sys = ~clk_sys;
  bsp_stat_pm bsp_stat_pm_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dword_moved(dword_moved), .read_req(read_req), .read_done(read_done), .wake_event(wake_event),
    .wake_signal_enable(wake_signal_enable), .wake_request_n(wake_request_n), .irq(irq));
  bsp_engine_model bsp_engine_model_inst (.clk_sys(clk_sys), .dword_moved(dword_moved),
    .read_req(read_req), .read_done(read_done), .wake_event(wake_event));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // reads queue {pslverr, prdata}; the monitor compares at the access edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] exp);
    int n;
    if (!wr) rq.push_back(exp);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      errors++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge clk_sys) if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0)
    check({pslverr, prdata}, rq.pop_front());
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h55b149ff));
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(0, bsp_stat_off, 0, 33'h0);
    apb(0, bsp_pmcs_off, 0, 33'h0);
    apb(0, 12'h010, 0, {1'b1, 32'h0});
    bsp_engine_model_inst.burst(5, s);
    bsp_engine_model_inst.fetch(3);
    apb(0, bsp_stat_off, 0, {1'b0, 16'h0003, 8'h0, 8'(s)});
    apb(0, bsp_stat_off, 0, 33'h0);
    bsp_engine_model_inst.burst(70, s);
    apb(0, bsp_stat_off, 0, {17'h0, 8'h0, (s > 255) ? 8'hff : 8'(s)});
    apb(0, bsp_isr_off, 0, {31'h0, s > 255, 1'b0});
    bsp_engine_model_inst.wake();
    #1 check({32'h0, wake_request_n}, 33'h1);
    apb(0, bsp_pmcs_off, 0, 33'h8000);
    wake_signal_enable <= 1'b1;
    d = $urandom;
    apb(1, bsp_pmcs_off, d & ~32'h8000, 0);
    #1 check({32'h0, wake_request_n}, 33'h0);
    apb(0, bsp_pmcs_off, 0, 33'h8000);
    apb(1, bsp_pmcs_off, d | 32'h8000, 0);
    #1 check({32'h0, wake_request_n}, 33'h1);
    apb(0, bsp_pmcs_off, 0, 33'h0);
    apb(1, bsp_imr_off, 32'h1, 0);
    apb(0, bsp_imr_off, 0, 33'h1);
    #1 check({32'h0, irq}, 33'h1);
    apb(0, bsp_isr_off, 0, 33'h1);
    #1 check({32'h0, irq}, 33'h0);
    wrap_up();
  end
endmodule // bus_statistics_and_pm_status_tb
